// ---- core/rrs_core.sv ----
`timescale 1ns/1ps
`default_nettype none

module rrs_core
(
    input wire logic clk_sys, // instruction clock
    input wire logic rst_n, // async reset
    input wire logic instr_valid, // instruction offered
    input wire rrs_pkg::rrs_instr_s instr, // decoded instruction
    output logic instr_ready, // instruction taken
    input wire logic [rrs_pkg::DATA_W-1:0] file_rdata, // addressed file value
    input wire logic carry_in, // current carry flag
    input wire logic [rrs_pkg::PC_W-1:0] stack_top_entry, // stack top
    input wire logic wake_event, // wake-up from sleep
    output rrs_pkg::rrs_wb_s wb, // writeback, one-cycle strobes
    output logic pc_load, // pc load strobe
    output logic [rrs_pkg::PC_W-1:0] pc_value, // pc load value
    output logic stack_pop, // stack pop strobe
    output logic global_irq_enable, // global interrupt enable
    output logic watchdog_clear, // clear watchdog and prescaler
    output logic [7:0] watchdog_counter_load, // watchdog load value
    output logic timeout_flag_n, // time-out flag, active low
    output logic powerdown_flag_n, // power-down flag, active low
    output logic osc_halt // oscillator stop request
);

    // ****************************************
    // decode
    // ****************************************
    rrs_pkg::rrs_state_e state_reg, state_next;
    wire logic idle = (state_reg == rrs_pkg::RRS_ST_IDLE);
    wire logic take = instr_valid && idle;
    wire logic is_retfi = take && (instr.op == rrs_pkg::RRS_OP_RETFI);
    wire logic is_retlit = take && (instr.op == rrs_pkg::RRS_OP_RETLIT);
    wire logic is_ret = take && (instr.op == rrs_pkg::RRS_OP_RETURN);
    wire logic is_rotl = take && (instr.op == rrs_pkg::RRS_OP_ROTL);
    wire logic is_rotr = take && (instr.op == rrs_pkg::RRS_OP_ROTR);
    wire logic is_sleep = take && (instr.op == rrs_pkg::RRS_OP_SLEEP);
    wire logic any_ret = is_retfi || is_retlit || is_ret;
    wire logic any_rot = is_rotl || is_rotr;

    // rotate through carry
    wire logic [rrs_pkg::DATA_W-1:0] rotl_val =
        {file_rdata[rrs_pkg::MSB_IDX-1:rrs_pkg::LSB_IDX], carry_in};
    wire logic [rrs_pkg::DATA_W-1:0] rotr_val =
        {carry_in, file_rdata[rrs_pkg::MSB_IDX:rrs_pkg::LSB_IDX+1]};
    wire logic [rrs_pkg::DATA_W-1:0] rot_val = is_rotl ? rotl_val : rotr_val;
    wire logic rot_carry = is_rotl ? file_rdata[rrs_pkg::MSB_IDX] : file_rdata[rrs_pkg::LSB_IDX];

    assign instr_ready = idle;

    // ****************************************
    // state
    // ****************************************
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            rrs_pkg::RRS_ST_IDLE:
            begin
                if (any_ret)
                    state_next = rrs_pkg::RRS_ST_REFILL;
                else if (is_sleep)
                    state_next = rrs_pkg::RRS_ST_ASLEEP;
            end
            rrs_pkg::RRS_ST_REFILL: state_next = rrs_pkg::RRS_ST_IDLE;
            rrs_pkg::RRS_ST_ASLEEP:
            begin
                if (wake_event)
                    state_next = rrs_pkg::RRS_ST_IDLE;
            end
            default: state_next = rrs_pkg::RRS_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            state_reg <= rrs_pkg::RRS_ST_IDLE;
        else
            state_reg <= state_next;
    end

    // ****************************************
    // outputs
    // ****************************************
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wb <= '0;
            pc_load <= 1'b0;
            pc_value <= '0;
            stack_pop <= 1'b0;
            watchdog_clear <= 1'b0;
        end
        else
        begin
            wb.acc_we <= is_retlit || (any_rot && instr.dest == rrs_pkg::DEST_ACC);
            wb.acc_data <= is_retlit ? instr.literal : rot_val;
            wb.file_we <= any_rot && (instr.dest == rrs_pkg::DEST_FILE);
            wb.file_addr <= instr.faddr;
            wb.file_data <= rot_val;
            wb.carry_we <= any_rot;
            wb.carry <= rot_carry;
            pc_load <= any_ret;
            pc_value <= stack_top_entry;
            stack_pop <= any_ret;
            watchdog_clear <= is_sleep;
        end
    end

    assign watchdog_counter_load = rrs_pkg::WDOG_CLEAR;
    assign osc_halt = (state_reg == rrs_pkg::RRS_ST_ASLEEP);

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            global_irq_enable <= 1'b0;
            timeout_flag_n <= rrs_pkg::TMO_N_RST;
            powerdown_flag_n <= rrs_pkg::PWD_N_RST;
        end
        else
        begin
            if (is_retfi)
                global_irq_enable <= rrs_pkg::IRQ_EN_ON;
            if (is_sleep)
            begin
                timeout_flag_n <= rrs_pkg::TMO_N_SLEEP;
                powerdown_flag_n <= rrs_pkg::PWD_N_SLEEP;
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    property p_retfi_irq_en;
        @(posedge clk_sys) disable iff (!rst_n)
        is_retfi |=> global_irq_enable && pc_load && !wb.carry_we && !wb.acc_we;
    endproperty
    a_retfi_irq_en: assert property (p_retfi_irq_en) else $error("irq return lacks enable or pc");

    property p_retfi_two;
        @(posedge clk_sys) disable iff (!rst_n)
        is_retfi |=> stack_pop && !instr_ready ##1 instr_ready;
    endproperty
    a_retfi_two: assert property (p_retfi_two) else $error("retfi timing");

    property p_rotl;
        @(posedge clk_sys) disable iff (!rst_n)
        is_rotl |=> wb.carry == $past(file_rdata[7])
            && wb.file_data == {$past(file_rdata[6:0]), $past(carry_in)};
    endproperty
    a_rotl: assert property (p_rotl) else $error("rotate left wrong");

    property p_rotr;
        @(posedge clk_sys) disable iff (!rst_n)
        is_rotr |=> wb.carry == $past(file_rdata[0])
            && wb.file_data == {$past(carry_in), $past(file_rdata[7:1])};
    endproperty
    a_rotr: assert property (p_rotr) else $error("rotate right wrong");

    property p_rot_dest;
        @(posedge clk_sys) disable iff (!rst_n)
        any_rot |=> wb.carry_we && (wb.file_we == $past(instr.dest))
            && (wb.acc_we != $past(instr.dest));
    endproperty
    a_rot_dest: assert property (p_rot_dest) else $error("rotate destination");

    property p_retlit;
        @(posedge clk_sys) disable iff (!rst_n)
        is_retlit |=> wb.acc_we && wb.acc_data == $past(instr.literal)
            && pc_value == $past(stack_top_entry) && !wb.carry_we;
    endproperty
    a_retlit: assert property (p_retlit) else $error("literal return wrong");

    property p_ret;
        @(posedge clk_sys) disable iff (!rst_n)
        is_ret |=> stack_pop && pc_load && pc_value == $past(stack_top_entry) && !wb.carry_we;
    endproperty
    a_ret: assert property (p_ret) else $error("return wrong");

    property p_ret_two;
        @(posedge clk_sys) disable iff (!rst_n)
        (is_ret || is_retlit) |=> !instr_ready ##1 instr_ready;
    endproperty
    a_ret_two: assert property (p_ret_two) else $error("return not two cycles");

    property p_sleep_wdog;
        @(posedge clk_sys) disable iff (!rst_n)
        is_sleep |=> watchdog_clear && watchdog_counter_load == 8'h00;
    endproperty
    a_sleep_wdog: assert property (p_sleep_wdog) else $error("watchdog not cleared");

    property p_sleep_flags;
        @(posedge clk_sys) disable iff (!rst_n)
        is_sleep |=> timeout_flag_n && !powerdown_flag_n;
    endproperty
    a_sleep_flags: assert property (p_sleep_flags) else $error("sleep flags wrong");

    property p_sleep_halt;
        @(posedge clk_sys) disable iff (!rst_n)
        is_sleep ##1 !wake_event |=> osc_halt && !instr_ready;
    endproperty
    a_sleep_halt: assert property (p_sleep_halt) else $error("not halted");

endmodule

`default_nettype wire

// ---- core/rrs_pkg.sv ----
`default_nettype none

package rrs_pkg;

    // ****************************************
    // widths and encodings
    // ****************************************
    localparam int DATA_W = 8;
    localparam int PC_W = 13;
    localparam int FADDR_W = 7;
    localparam int MSB_IDX = 7;
    localparam int LSB_IDX = 0;
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_FILE = 1'b1;
    localparam logic IRQ_EN_ON = 1'b1;
    localparam logic TMO_N_SLEEP = 1'b1;
    localparam logic PWD_N_SLEEP = 1'b0;
    localparam logic TMO_N_RST = 1'b1;
    localparam logic PWD_N_RST = 1'b1;
    localparam logic [7:0] WDOG_CLEAR = 8'h00;

    typedef enum logic [2:0]
    {
        RRS_OP_NONE = 3'h0,
        RRS_OP_RETFI = 3'h1,
        RRS_OP_RETLIT = 3'h2,
        RRS_OP_RETURN = 3'h3,
        RRS_OP_ROTL = 3'h4,
        RRS_OP_ROTR = 3'h5,
        RRS_OP_SLEEP = 3'h6
    } rrs_op_e;

    typedef enum logic [3:0]
    {
        RRS_ST_IDLE = 4'b0001,
        RRS_ST_REFILL = 4'b0010,
        RRS_ST_ASLEEP = 4'b0100,
        RRS_ST_SPARE = 4'b1000
    } rrs_state_e;

    typedef struct packed
    {
        rrs_op_e op;
        logic dest;
        logic [FADDR_W-1:0] faddr;
        logic [DATA_W-1:0] literal;
    } rrs_instr_s;

    typedef struct packed
    {
        logic acc_we;
        logic [DATA_W-1:0] acc_data;
        logic file_we;
        logic [FADDR_W-1:0] file_addr;
        logic [DATA_W-1:0] file_data;
        logic carry_we;
        logic carry;
    } rrs_wb_s;

endpackage

`default_nettype wire

// ---- sim/rrs_core_bench.sv ----
`timescale 1ns/1ps
`default_nettype none

module rrs_core_bench;
    logic clk_sys;
    logic rst_n;
    logic instr_valid;
    rrs_pkg::rrs_instr_s instr;
    logic instr_ready;
    logic [7:0] file_rdata;
    logic carry_in;
    logic [12:0] stack_top_entry;
    logic wake_event;
    rrs_pkg::rrs_wb_s wb;
    logic pc_load;
    logic [12:0] pc_value;
    logic stack_pop;
    logic global_irq_enable;
    logic watchdog_clear;
    logic [7:0] watchdog_counter_load;
    logic timeout_flag_n;
    logic powerdown_flag_n;
    logic osc_halt;
    int err_total;
    int n_checks;

    rrs_core u_rrs_core (.clk_sys(clk_sys), .rst_n(rst_n), .instr_valid(instr_valid),
        .instr(instr), .instr_ready(instr_ready), .file_rdata(file_rdata),
        .carry_in(carry_in), .stack_top_entry(stack_top_entry), .wake_event(wake_event),
        .wb(wb), .pc_load(pc_load), .pc_value(pc_value), .stack_pop(stack_pop),
        .global_irq_enable(global_irq_enable), .watchdog_clear(watchdog_clear),
        .watchdog_counter_load(watchdog_counter_load), .timeout_flag_n(timeout_flag_n),
        .powerdown_flag_n(powerdown_flag_n), .osc_halt(osc_halt));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        while (instr_ready !== 1'b1 && n < 40)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n >= 40)
        begin
            chk("ready wait", 16'h0001, 16'h0000);
            give_verdict();
        end
    endtask

    // offer one instruction; returns 1 ns after the take edge
    task automatic issue(input rrs_pkg::rrs_op_e op, input logic d, input logic [7:0] lit,
        input logic [7:0] fdat, input logic cin, input logic [12:0] stk);
        wait_ready();
        @(posedge clk_sys);
        instr_valid <= 1'b1;
        instr <= '{op: op, dest: d, faddr: 7'h2a, literal: lit};
        file_rdata <= fdat;
        carry_in <= cin;
        stack_top_entry <= stk;
        @(posedge clk_sys);
        instr_valid <= 1'b0;
        #1;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_returns();
        rrs_pkg::rrs_op_e ops[3];
        ops = '{rrs_pkg::RRS_OP_RETURN, rrs_pkg::RRS_OP_RETLIT, rrs_pkg::RRS_OP_RETFI};
        foreach (ops[i])
        begin
            issue(ops[i], 1'b0, 8'hc3 + 8'(i), 8'h00, 1'b1, 13'h1abc - 13'(i));
            chk("pc_load", 16'h0001, {15'h0000, pc_load});
            chk("pc_value", {3'h0, 13'h1abc - 13'(i)}, {3'h0, pc_value});
            chk("stack_pop", 16'h0001, {15'h0000, stack_pop});
            chk("carry_we", 16'h0000, {15'h0000, wb.carry_we});
            chk("acc_we", {15'h0000, i == 1}, {15'h0000, wb.acc_we});
            if (i == 1)
                chk("acc_data", {8'h00, 8'hc4}, {8'h00, wb.acc_data});
            chk("irq_enable", {15'h0000, i == 2}, {15'h0000, global_irq_enable});
            chk("ready refill", 16'h0000, {15'h0000, instr_ready});
            @(posedge clk_sys);
            #1;
            chk("ready after", 16'h0001, {15'h0000, instr_ready});
            chk("pc_load end", 16'h0000, {15'h0000, pc_load});
        end
        $display("test returns done");
    endtask

    task automatic t_rotates();
        logic [7:0] dv;
        logic [7:0] res;
        logic c;
        rrs_pkg::rrs_op_e rop;
        for (int k = 0; k < 8; k++)
        begin
            dv = k[2] ? 8'h81 : 8'h6a;
            c = k[1];
            res = k[0] ? {c, dv[7:1]} : {dv[6:0], c};
            if (k[0])
                rop = rrs_pkg::RRS_OP_ROTR;
            else
                rop = rrs_pkg::RRS_OP_ROTL;
            issue(rop, k[2], 8'h00, dv, c, 13'h0000);
            chk("carry_we", 16'h0001, {15'h0000, wb.carry_we});
            chk("carry", {15'h0000, k[0] ? dv[0] : dv[7]}, {15'h0000, wb.carry});
            chk("acc_we", {15'h0000, !k[2]}, {15'h0000, wb.acc_we});
            chk("file_we", {15'h0000, k[2]}, {15'h0000, wb.file_we});
            chk("pc_load", 16'h0000, {15'h0000, pc_load});
            if (k[2])
            begin
                chk("file_data", {8'h00, res}, {8'h00, wb.file_data});
                chk("file_addr", 16'h002a, {9'h000, wb.file_addr});
            end
            else
                chk("acc_data", {8'h00, res}, {8'h00, wb.acc_data});
        end
        $display("test rotates done");
    endtask

    task automatic t_sleep();
        issue(rrs_pkg::RRS_OP_NONE, 1'b1, 8'h00, 8'h00, 1'b0, 13'h0000);
        chk("none ignored", 16'h0000, {12'h000, wb.acc_we, wb.file_we, pc_load, watchdog_clear});
        issue(rrs_pkg::RRS_OP_SLEEP, 1'b0, 8'h00, 8'h00, 1'b0, 13'h0000);
        chk("watchdog clear", 16'h0001, {15'h0000, watchdog_clear});
        chk("watchdog load", 16'h0000, {8'h00, watchdog_counter_load});
        chk("timeout_n", 16'h0001, {15'h0000, timeout_flag_n});
        chk("powerdown_n", 16'h0000, {15'h0000, powerdown_flag_n});
        chk("osc_halt", 16'h0001, {15'h0000, osc_halt});
        repeat (5) @(posedge clk_sys);
        #1;
        chk("asleep ready", 16'h0000, {15'h0000, instr_ready});
        chk("asleep halt", 16'h0001, {15'h0000, osc_halt});
        chk("watchdog pulse", 16'h0000, {15'h0000, watchdog_clear});
        @(posedge clk_sys);
        wake_event <= 1'b1;
        wait_ready();
        @(posedge clk_sys);
        wake_event <= 1'b0;
        #1;
        chk("woken", 16'h0000, {15'h0000, osc_halt});
        $display("test sleep done");
    endtask

    // ****************************************
    // clock, reset, sequence
    // ****************************************
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    initial
    begin
        err_total = 0;
        n_checks = 0;
        rst_n = 1'b0;
        instr_valid = 1'b0;
        instr = '0;
        file_rdata = 8'h00;
        carry_in = 1'b0;
        stack_top_entry = 13'h0000;
        wake_event = 1'b0;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        #1;
        chk("reset flags", 16'h0003, {13'h0000, global_irq_enable, timeout_flag_n,
            powerdown_flag_n});
        chk("reset halt", 16'h0000, {15'h0000, osc_halt});
        $display("test reset done");
        t_returns();
        t_rotates();
        t_sleep();
        give_verdict();
    end
endmodule

`default_nettype wire
